// File: esl_led_model.sv
// Purpose: two-colour lamp model that counts lit cycles of each colour
// Assumes: lamp drive comes from registered outputs on clk_sys
// Notes: both colours lit at once counts toward neither colour
`timescale 1ns/10ps
`default_nettype none
module esl_led_model (
	// clock and control
	input wire logic clk_sys,
	input wire logic clear,
	// lamp drive
	input wire logic green,
	input wire logic red,
	// time lit
	output var logic [15:0] greenCnt,
	output var logic [15:0] redCnt
);
	always_ff @(posedge clk_sys) begin
		if (clear) begin
			greenCnt <= 16'h0;
			redCnt <= 16'h0;
		end else begin
			greenCnt <= greenCnt + 16'(green === 1'b1 && red === 1'b0);
			redCnt <= redCnt + 16'(red === 1'b1 && green === 1'b0);
		end
	end
endmodule : esl_led_model
`default_nettype wire

// File: esl_pkg.sv
// Purpose: shared constants and types for the scanner status indicator block
// Assumes: 100 MHz system clock, millisecond timebase derived by prescaler
// Notes: register offsets are byte addresses of 32-bit words
package esl_pkg;

	// ------------------------------------------------------------
	// clock and time
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int PRESCALE_DEFAULT = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PRE_W = 17;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_PERIOD_MS = 2 * BLINK_HALF_MS;
	localparam int SELFTEST_STEP_MS = 250;
	localparam int FLICKER_HALF_MS = 50;
	localparam int FLICKER_PERIOD_MS = 2 * FLICKER_HALF_MS;
	localparam int BLINK_W = 10;
	localparam int STEP_W = 8;
	localparam int FLK_W = 7;
	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_PERIOD_MS - 1);
	localparam logic [BLINK_W-1:0] BLINK_ON_LIMIT = BLINK_W'(BLINK_HALF_MS);
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(SELFTEST_STEP_MS - 1);
	localparam logic [FLK_W-1:0] FLK_LOAD = FLK_W'(FLICKER_PERIOD_MS);
	localparam logic [FLK_W-1:0] FLK_ON_ABOVE = FLK_W'(FLICKER_HALF_MS);

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0c;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'h1;
	localparam int IRQ_W = 4;
	localparam int IRQ_SELFTEST_DONE = 0;
	localparam int IRQ_UNRECOVERABLE = 1;
	localparam int IRQ_DUPLICATE_IP = 2;
	localparam int IRQ_OWNER_TIMEOUT = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
	localparam int STS_MS_LSB = 0;
	localparam int STS_NS_LSB = 2;
	localparam int STS_LINK_LSB = 4;
	localparam int STS_ACT_LSB = 6;
	localparam int STS_STATE_LSB = 8;
	localparam int STS_EO_BIT = 11;

	// ------------------------------------------------------------
	// self-test sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_MS_GREEN = 3'h0,
		ST_MS_RED = 3'h1,
		ST_NS_GREEN = 3'h2,
		ST_NS_RED = 3'h3,
		ST_HOLD = 3'h4,
		ST_RUN = 3'h5
	} esl_seq_t;

endpackage : esl_pkg

// File: esl_status_leds.sv
// Purpose: module, network, link and activity indicator pattern generator
// Assumes: all status inputs come from logic on clk_sys
// Notes: plain register port, read data one cycle after the read strobe
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - module indicator steady green while device operates correctly
// - module indicator flashes green at 1 Hz while unconfigured
// - self-test runs module sequence first, network indicator off meanwhile
// - module self-test: green 250 ms, red 250 ms, green until test done
// - network self-test: green 250 ms, red 250 ms, off until test done
// - recoverable fault blinks module indicator red at 1 Hz
// - unrecoverable fault shows module indicator steady red
// - network steady green with IP, a connection, no owner timeout
// - network flashes green at 1 Hz with IP but no connection
// - network blinks red at 1 Hz after an owner connection timeout
// - steady green returns only once all timed-out owners re-established; here eoLatch clears when cipConnected is high and ownerTimedOut low
// - duplicate IP shows network indicator steady red
// - network indicator dark after self-test whenever no IP address is assigned
// - link indicator of each port lit while that port has link
// - activity indicator flickers on frames, dark otherwise
// - 1 Hz pattern is 500 ms on then 500 ms off
// - activity flicker 50 ms on, 50 ms off, retriggered by frames
module esl_status_leds #(
	parameter int PRESCALE_CYCLES = esl_pkg::PRESCALE_DEFAULT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [esl_pkg::ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	output logic irq,
	// device state
	input wire logic powerUpDone,
	input wire logic configured,
	input wire logic operational,
	input wire logic recoverableFault,
	input wire logic unrecoverableFault,
	input wire logic ipSet,
	input wire logic cipConnected,
	input wire logic ownerTimedOut,
	input wire logic duplicateIp,
	input wire logic [1:0] linkUp,
	input wire logic [1:0] frameSeen,
	// indicators
	output logic msGreen,
	output logic msRed,
	output logic nsGreen,
	output logic nsRed,
	output logic [1:0] portLinkLed,
	output logic [1:0] frameActivityLed
);
	import esl_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [PRE_W-1:0] preCnt;
		logic msTick;
		logic [BLINK_W-1:0] blinkMs;
		logic [STEP_W-1:0] stepMs;
		esl_seq_t seq;
		logic [1:0][FLK_W-1:0] actCnt;
		logic [1:0] actPend;
		logic eoLatch;
		logic enable;
		logic [IRQ_W-1:0] irqStatus;
		logic [IRQ_W-1:0] irqMask;
		logic [2:0] prevEvt;
		logic [31:0] rdData;
		logic irq;
		logic msG;
		logic msR;
		logic nsG;
		logic nsR;
		logic [1:0] link;
		logic [1:0] act;
	} esl_state_t;

	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_CYCLES - 1);

	esl_state_t state_reg;
	esl_state_t state_next;

	function automatic logic eslRise(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction : eslRise

	logic blinkOn;
	logic [IRQ_W-1:0] evt;
	logic [31:0] statusWord;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		// millisecond timebase and 1 Hz phase
		state_next.msTick = 1'b0;
		if (state_reg.preCnt == PRE_LAST) begin
			state_next.preCnt = '0;
			state_next.msTick = 1'b1;
		end else begin
			state_next.preCnt = state_reg.preCnt + PRE_W'(1);
		end
		if (state_reg.msTick) begin
			if (state_reg.blinkMs == BLINK_LAST) begin
				state_next.blinkMs = '0;
			end else begin
				state_next.blinkMs = state_reg.blinkMs + BLINK_W'(1);
			end
		end
		blinkOn = state_reg.blinkMs < BLINK_ON_LIMIT;

		// power-up lamp sequence
		if (state_reg.msTick && state_reg.seq < ST_HOLD) begin
			if (state_reg.stepMs == STEP_LAST) begin
				state_next.stepMs = '0;
			end else begin
				state_next.stepMs = state_reg.stepMs + STEP_W'(1);
			end
		end
		unique case (state_reg.seq)
			ST_MS_GREEN: begin
				if (state_reg.msTick && state_reg.stepMs == STEP_LAST) begin
					state_next.seq = ST_MS_RED;
				end
			end
			ST_MS_RED: begin
				if (state_reg.msTick && state_reg.stepMs == STEP_LAST) begin
					state_next.seq = ST_NS_GREEN;
				end
			end
			ST_NS_GREEN: begin
				if (state_reg.msTick && state_reg.stepMs == STEP_LAST) begin
					state_next.seq = ST_NS_RED;
				end
			end
			ST_NS_RED: begin
				if (state_reg.msTick && state_reg.stepMs == STEP_LAST) begin
					state_next.seq = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (powerUpDone) begin
					state_next.seq = ST_RUN;
				end
			end
			ST_RUN: begin
				state_next.seq = ST_RUN;
			end
			default: begin
				state_next.seq = ST_MS_GREEN;
			end
		endcase

		// owner timeout stays latched until connections are back
		if (ownerTimedOut) begin
			state_next.eoLatch = 1'b1;
		end else if (cipConnected) begin
			state_next.eoLatch = 1'b0;
		end

		// module indicator
		state_next.msG = 1'b0;
		state_next.msR = 1'b0;
		if (state_reg.seq != ST_RUN) begin
			state_next.msG = state_reg.seq != ST_MS_RED;
			state_next.msR = state_reg.seq == ST_MS_RED;
		end else if (unrecoverableFault) begin
			state_next.msR = 1'b1;
		end else if (recoverableFault) begin
			state_next.msR = blinkOn;
		end else if (!configured) begin
			state_next.msG = blinkOn;
		end else if (operational) begin
			state_next.msG = 1'b1;
		end

		// network indicator
		state_next.nsG = 1'b0;
		state_next.nsR = 1'b0;
		if (state_reg.seq != ST_RUN) begin
			state_next.nsG = state_reg.seq == ST_NS_GREEN;
			state_next.nsR = state_reg.seq == ST_NS_RED;
		end else if (!ipSet) begin
			state_next.nsG = 1'b0;
		end else if (duplicateIp) begin
			state_next.nsR = 1'b1;
		end else if (state_reg.eoLatch || ownerTimedOut) begin
			state_next.nsR = blinkOn;
		end else if (cipConnected) begin
			state_next.nsG = 1'b1;
		end else begin
			state_next.nsG = blinkOn;
		end

		// link and activity per port
		for (int p = 0; p < 2; p++) begin
			state_next.link[p] = linkUp[p];
			state_next.actPend[p] = state_reg.actPend[p] | frameSeen[p];
			if (state_reg.actCnt[p] == '0) begin
				if (state_reg.actPend[p] || frameSeen[p]) begin
					state_next.actCnt[p] = FLK_LOAD;
					state_next.actPend[p] = 1'b0;
				end
			end else if (state_reg.msTick) begin
				state_next.actCnt[p] = state_reg.actCnt[p] - FLK_W'(1);
			end
			state_next.act[p] = state_next.actCnt[p] > FLK_ON_ABOVE;
		end

		// software enable darkens all indicators
		if (!state_reg.enable) begin
			state_next.msG = 1'b0;
			state_next.msR = 1'b0;
			state_next.nsG = 1'b0;
			state_next.nsR = 1'b0;
			state_next.link = 2'h0;
			state_next.act = 2'h0;
		end

		// events: set wins over a write-one clear
		evt = '0;
		evt[IRQ_SELFTEST_DONE] = state_reg.seq == ST_HOLD && powerUpDone;
		evt[IRQ_UNRECOVERABLE] = eslRise(state_reg.prevEvt[0], unrecoverableFault);
		evt[IRQ_DUPLICATE_IP] = eslRise(state_reg.prevEvt[1], duplicateIp);
		evt[IRQ_OWNER_TIMEOUT] = eslRise(state_reg.prevEvt[2], ownerTimedOut);
		state_next.prevEvt = {ownerTimedOut, duplicateIp, unrecoverableFault};

		// register writes
		if (regWrite) begin
			unique case (regAddr)
				REG_CTRL: state_next.enable = regWrData[CTRL_ENABLE_BIT];
				REG_IRQ_STATUS: state_next.irqStatus = state_reg.irqStatus & ~regWrData[IRQ_W-1:0];
				REG_IRQ_MASK: state_next.irqMask = regWrData[IRQ_W-1:0];
				default: state_next.irqMask = state_reg.irqMask;
			endcase
		end
		state_next.irqStatus = state_next.irqStatus | evt;
		state_next.irq = |(state_next.irqStatus & state_next.irqMask);

		// register reads
		statusWord = '0;
		statusWord[STS_MS_LSB +: 2] = {state_reg.msR, state_reg.msG};
		statusWord[STS_NS_LSB +: 2] = {state_reg.nsR, state_reg.nsG};
		statusWord[STS_LINK_LSB +: 2] = state_reg.link;
		statusWord[STS_ACT_LSB +: 2] = state_reg.act;
		statusWord[STS_STATE_LSB +: 3] = state_reg.seq;
		statusWord[STS_EO_BIT] = state_reg.eoLatch;
		state_next.rdData = '0;
		if (regRead) begin
			unique case (regAddr)
				REG_CTRL: state_next.rdData = {31'h0, state_reg.enable};
				REG_STATUS: state_next.rdData = statusWord;
				REG_IRQ_STATUS: state_next.rdData = {28'h0, state_reg.irqStatus};
				REG_IRQ_MASK: state_next.rdData = {28'h0, state_reg.irqMask};
				default: state_next.rdData = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.seq <= ST_MS_GREEN;
			state_reg.enable <= CTRL_ENABLE_RESET;
			state_reg.irqMask <= IRQ_MASK_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign regRdData = state_reg.rdData;
	assign irq = state_reg.irq;
	assign msGreen = state_reg.msG;
	assign msRed = state_reg.msR;
	assign nsGreen = state_reg.nsG;
	assign nsRed = state_reg.nsR;
	assign portLinkLed = state_reg.link;
	assign frameActivityLed = state_reg.act;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_ms_step_green: assert property (
		state_reg.seq == ST_MS_GREEN && state_reg.msTick && state_reg.stepMs == STEP_LAST
		|=> state_reg.seq == ST_MS_RED ##1 msRed && !msGreen)
		else $error("module self-test did not turn red after its green step");

	a_ns_off_early: assert property (
		state_reg.seq inside {ST_MS_GREEN, ST_MS_RED} |=> !nsGreen && !nsRed)
		else $error("network indicator lit during module self-test");

	a_ns_step_red: assert property (
		state_reg.seq == ST_NS_RED && state_reg.enable |=> nsRed && !nsGreen && msGreen)
		else $error("network self-test red step wrong");

	a_ms_unrec_red: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && unrecoverableFault
		|=> msRed && !msGreen)
		else $error("unrecoverable fault not steady red");

	a_ms_blink_red: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && !unrecoverableFault && recoverableFault
		|=> msRed == $past(state_reg.blinkMs < BLINK_ON_LIMIT) && !msGreen)
		else $error("recoverable fault blink wrong");

	a_ms_run_green: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && !unrecoverableFault && !recoverableFault
		&& configured && operational |=> msGreen && !msRed)
		else $error("operating device not steady green");

	a_blink_wrap: assert property (
		state_reg.msTick && state_reg.blinkMs == BLINK_LAST |=> state_reg.blinkMs == '0)
		else $error("1 Hz phase did not wrap at its period");

	a_ns_dark_noip: assert property (
		state_reg.seq == ST_RUN && !ipSet |=> !nsGreen && !nsRed)
		else $error("network indicator lit without address");

	a_ns_dup_red: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && ipSet && duplicateIp
		|=> nsRed && !nsGreen)
		else $error("duplicate address not steady red");

	a_ns_conn_green: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && ipSet && !duplicateIp && !state_reg.eoLatch
		&& !ownerTimedOut && cipConnected |=> nsGreen && !nsRed)
		else $error("connected network indicator not steady green");

	a_ns_blink_green: assert property (
		state_reg.seq == ST_RUN && state_reg.enable && ipSet && !duplicateIp && !state_reg.eoLatch
		&& !ownerTimedOut && !cipConnected
		|=> nsGreen == $past(state_reg.blinkMs < BLINK_ON_LIMIT) && !nsRed)
		else $error("network indicator not flashing green without connections");

	a_eo_latch_hold: assert property (
		state_reg.eoLatch && !cipConnected |=> state_reg.eoLatch ##1 !nsGreen || !ipSet)
		else $error("owner timeout released without connection");

	// the release edge still shows reset state, so it must not start an attempt
	a_link_follow: assert property (
		!reset && state_reg.enable && linkUp[0] |=> portLinkLed[0])
		else $error("link indicator not following link");

	a_act_start: assert property (
		!reset && state_reg.enable && state_reg.actCnt[0] == '0 && frameSeen[0]
		|=> frameActivityLed[0] && state_reg.actCnt[0] == FLK_LOAD)
		else $error("activity flicker did not start on a frame");

	a_irq_unrec: assert property (
		!state_reg.prevEvt[0] && unrecoverableFault && state_reg.irqMask[IRQ_UNRECOVERABLE]
		|=> irq && state_reg.irqStatus[IRQ_UNRECOVERABLE])
		else $error("fault event did not raise the interrupt");

	a_rd_zero: assert property (!regRead |=> regRdData == 32'h0)
		else $error("read data present without a read");

	c_selftest_done: cover property (state_reg.seq == ST_HOLD ##1 state_reg.seq == ST_RUN);
	c_act_reload: cover property (state_reg.actCnt[1] == 7'h1 && state_reg.actPend[1]);
	c_eo_blink: cover property (nsRed && state_reg.eoLatch);
	c_irq_raise: cover property ($rose(irq));

endmodule : esl_status_leds

`default_nettype wire

// File: esl_status_leds_tb.sv
// Purpose: self-checking bench for the status indicator generator
// Assumes: prescaler shortened to 4 cycles per millisecond
// Notes: blink counts are taken over whole periods so phase does not matter
`timescale 1ns/10ps
`default_nettype none
module esl_status_leds_tb;
	import esl_pkg::*;
	localparam int PRE = 4;
	localparam int WIN = BLINK_PERIOD_MS * PRE;
	localparam int STEP = SELFTEST_STEP_MS * PRE;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [31:0] regWrData = '0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData;
	logic irq;
	logic [7:0] state = '0;
	logic powerUpDone = 1'b0;
	logic [1:0] linkUp = '0;
	logic [1:0] frameSeen = '0;
	logic msGreen, msRed, nsGreen, nsRed;
	logic [1:0] portLinkLed, frameActivityLed;
	logic clear = 1'b1;
	logic rdLag = 1'b0;
	wire logic [63:0] gCnt, rCnt;
	logic [31:0] expQ [$];
	logic [31:0] mskQ [$];
	int failures = 0;
	int checksDone = 0;
	int seed = 32'h966f;

	// ------------------------------------------------------------
	// design and lamps
	// ------------------------------------------------------------
	esl_status_leds #(.PRESCALE_CYCLES(PRE)) esl_status_leds_inst (.clk_sys(clk_sys), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .irq(irq), .powerUpDone(powerUpDone), .configured(state[7]),
		.operational(state[6]), .recoverableFault(state[5]), .unrecoverableFault(state[4]),
		.ipSet(state[3]), .cipConnected(state[2]), .ownerTimedOut(state[1]), .duplicateIp(state[0]),
		.linkUp(linkUp), .frameSeen(frameSeen), .msGreen(msGreen), .msRed(msRed), .nsGreen(nsGreen),
		.nsRed(nsRed), .portLinkLed(portLinkLed), .frameActivityLed(frameActivityLed));
	esl_led_model esl_led_model_inst [3:0] (.clk_sys(clk_sys), .clear(clear),
		.green({frameActivityLed, nsGreen, msGreen}), .red({2'b00, nsRed, msRed}),
		.greenCnt(gCnt), .redCnt(rCnt));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic near(input logic [15:0] a, input int b);
		int v;
		v = int'(a);
		return v >= b - b / 32 - 4 && v <= b + b / 32 + 4;
	endfunction : near

	always @(posedge clk_sys) begin
		logic [31:0] m;
		rdLag <= regRead;
		if (rdLag && expQ.size() > 0) begin
			m = mskQ.pop_front();
			check("regRdData", regRdData & m, expQ.pop_front() & m);
		end
	end

	task automatic close_out();
		if (failures == 0 && checksDone > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial begin
		#1000000;
		failures++;
		close_out();
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
	endtask : rd

	task automatic lamps(input string what, input int n, input int e [6]);
		clear <= 1'b1;
		@(posedge clk_sys);
		clear <= 1'b0;
		// one edge more: the counts of n samples are read before that edge updates them
		repeat (n + 1) @(posedge clk_sys);
		check({what, " msG"}, 32'(near(gCnt[15:0], e[0])), 32'h1);
		check({what, " msR"}, 32'(near(rCnt[15:0], e[1])), 32'h1);
		check({what, " nsG"}, 32'(near(gCnt[31:16], e[2])), 32'h1);
		check({what, " nsR"}, 32'(near(rCnt[31:16], e[3])), 32'h1);
		check({what, " act0"}, 32'(near(gCnt[47:32], e[4])), 32'h1);
		check({what, " act1"}, 32'(near(gCnt[63:48], e[5])), 32'h1);
	endtask : lamps

	task automatic selftest();
		logic [3:0] pat [5] = '{4'h8, 4'h4, 4'ha, 4'h9, 4'h8};
		reset <= 1'b1;
		powerUpDone <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			repeat (i == 0 ? STEP / 2 : STEP) @(posedge clk_sys);
			check("selftest", 32'({msGreen, msRed, nsGreen, nsRed}), 32'(pat[i]));
		end
		powerUpDone <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : selftest

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		static logic [7:0] st [8] = '{8'hcc, 8'h48, 8'h25, 8'hfe, 8'hc8, 8'hcd, 8'hcc, 8'h80};
		static int tbl [8][6] = '{'{WIN, 0, WIN, 0, 0, 0}, '{WIN/2, 0, WIN/2, 0, 0, 0}, '{0, WIN/2, 0, 0, 0, 0},
			'{0, WIN, 0, WIN/2, 0, 0}, '{WIN, 0, 0, WIN/2, 0, 0}, '{WIN, 0, 0, WIN, 0, 0},
			'{WIN, 0, WIN, 0, 0, 0}, '{0, 0, 0, 0, 0, 0}};
		logic [31:0] r;
		selftest();
		rd(REG_CTRL, 32'(CTRL_ENABLE_RESET), 32'h1);
		rd(REG_IRQ_MASK, 32'(IRQ_MASK_RESET), 32'hf);
		rd(REG_IRQ_STATUS, 32'h1 << IRQ_SELFTEST_DONE, 32'h1);
		rd(REG_STATUS, 32'(ST_RUN) << STS_STATE_LSB, 32'h700);
		rd(8'h10, 32'h0, 32'hffffffff);
		check("irq masked", 32'(irq), 32'h0);
		wr(REG_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		check("irq raised", 32'(irq), 32'h1);
		wr(REG_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		check("irq cleared", 32'(irq), 32'h0);
		r = $random(seed);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			linkUp <= 2'(i) ^ r[1:0];
			repeat (3) @(posedge clk_sys);
			check("portLinkLed", 32'(portLinkLed), 32'(linkUp));
		end
		linkUp <= 2'h3;
		wr(REG_CTRL, 32'h0);
		repeat (3) @(posedge clk_sys);
		check("disabled", 32'({msGreen, msRed, nsGreen, nsRed, portLinkLed}), 32'h0);
		wr(REG_CTRL, 32'h1);
		// rows: steady, standby, recoverable, unrecoverable, latch, dup ip, reconnected, off
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			state <= st[i];
			lamps("state", WIN, tbl[i]);
		end
		rd(REG_IRQ_STATUS, 32'he, 32'he);
		wr(REG_IRQ_MASK, 32'he);
		repeat (2) @(posedge clk_sys);
		check("irq events", 32'(irq), 32'h1);
		wr(REG_IRQ_STATUS, 32'he);
		repeat (2) @(posedge clk_sys);
		check("irq events clr", 32'(irq), 32'h0);
		frameSeen <= 2'b01;
		@(posedge clk_sys);
		frameSeen <= 2'b00;
		lamps("one frame", 2 * FLICKER_PERIOD_MS * PRE, '{0, 0, 0, 0, FLICKER_HALF_MS * PRE, 0});
		frameSeen <= 2'b10;
		lamps("busy", WIN, '{0, 0, 0, 0, 0, WIN/2});
		frameSeen <= 2'b00;
		state <= 8'hff;
		selftest();
		close_out();
	end
endmodule : esl_status_leds_tb
`default_nettype wire
